// ---- hdl/hlt_pkg.sv ----
// constants and types for the hardware limit timer mode control
package hlt_pkg;
  localparam int unsigned COUNT_W      = 8;
  localparam int unsigned MODE_W       = 5;
  localparam int unsigned POST_W       = 4;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  PERIOD_RST   = 8'hFF;
  localparam logic [3:0]  POST_RST     = 4'h0;
  localparam logic [1:0]  GRP_FREE     = 2'h0;
  localparam logic [1:0]  GRP_ONESHOT  = 2'h1;
  localparam logic [1:0]  GRP_MONO     = 2'h2;
  localparam logic [1:0]  RESUME_DELAY = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;
endpackage

// ---- hdl/sync2.sv ----
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;

  // pass input through
  always_comb begin
    next_stage1 = srst ? 1'b0 : din;
    next_dout   = srst ? 1'b0 : stage1;
  end

  // register both stages
  always_ff @(posedge ref_clk) begin
    stage1 <= next_stage1;
    dout   <= next_dout;
  end
endmodule // sync2

// ---- hdl/postscaler.sv ----
// postscaler counter producing a one-clock output pulse
`timescale 1ns/1ps
module postscaler
  import hlt_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  // control
  input  wire logic                       clear,
  input  wire logic                       match,
  input  wire logic [hlt_pkg::POST_W-1:0] postscale_select,
  // output
  output logic                            postscaled_pulse
);
  logic [POST_W-1:0] post_count;
  logic [POST_W-1:0] next_post_count;
  logic              next_pulse;

  // count matches, pulse when select reached
  always_comb begin
    next_post_count = post_count;
    next_pulse      = 1'b0;
    if (srst || clear) begin
      next_post_count = POST_RST;
    end else if (match) begin
      if (post_count == postscale_select) begin
        next_post_count = POST_RST;
        next_pulse      = 1'b1;
      end else begin
        next_post_count = post_count + 4'h1;
      end
    end
  end

  // register state
  always_ff @(posedge ref_clk) begin
    post_count       <= next_post_count;
    postscaled_pulse <= next_pulse;
  end
endmodule // postscaler

// ---- hdl/timer_hw_limit_mode_control.sv ----
// mode control for an 8-bit period timer with hardware limit
`timescale 1ns/1ps
module timer_hw_limit_mode_control
  import hlt_pkg::*;
(
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // software control
  input  wire logic                        enable_set,
  input  wire logic                        enable_clear,
  input  wire logic [hlt_pkg::MODE_W-1:0]  mode,
  input  wire logic [hlt_pkg::COUNT_W-1:0] period_value,
  input  wire logic [hlt_pkg::POST_W-1:0]  postscale_select,
  input  wire logic                        count_write,
  input  wire logic [hlt_pkg::COUNT_W-1:0] count_write_data,
  input  wire logic                        debug_mode,
  // external reset and trigger
  input  wire logic                        external_reset_trigger,
  // status
  output logic                             enable,
  output logic [hlt_pkg::COUNT_W-1:0]      count_value,
  output logic                             period_match,
  output logic                             postscaled_pulse
);
  import hlt_pkg::*;

  logic                ers_sync;
  logic                ers_prev;
  logic                next_ers_prev;
  logic                next_enable;
  logic [COUNT_W-1:0]  next_count;
  logic                next_match;
  run_state_t          state;
  run_state_t          next_state;
  logic [1:0]          hold_cnt;
  logic [1:0]          next_hold_cnt;
  logic                rise;
  logic                fall;
  logic                ers_lvl;
  logic [1:0]          grp;
  logic [2:0]          sub;
  logic                reserved;
  logic                start_ev;
  logic                edge_start;
  logic                reset_edge;
  logic                reset_lvl;
  logic                gate_ok;
  logic                at_match;
  logic                post_clear;

  // bring the external signal into the clock domain
  sync2 u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (external_reset_trigger),
    .dout    (ers_sync)
  );

  // mode decode and edge detect
  always_comb begin
    grp      = mode[4:3];
    sub      = mode[2:0];
    reserved = (grp == 2'h3) || (grp == GRP_MONO &&
               (sub == 3'h0 || sub == 3'h4 || sub == 3'h5));
    ers_lvl  = ers_sync && !debug_mode;
    rise     = ers_sync && !ers_prev && !debug_mode;
    fall     = !ers_sync && ers_prev && !debug_mode;
    gate_ok    = 1'b1;
    reset_edge = 1'b0;
    reset_lvl  = 1'b0;
    edge_start = 1'b0;
    start_ev   = 1'b0;
    case (grp)
      GRP_FREE: begin
        start_ev = 1'b1;
        case (sub)
          3'h1: gate_ok = debug_mode ? 1'b1 : ers_lvl;
          3'h2: gate_ok = debug_mode ? 1'b1 : !ers_lvl;
          3'h3: reset_edge = rise || fall;
          3'h4: reset_edge = rise;
          3'h5: reset_edge = fall;
          3'h6: reset_lvl = !debug_mode && !ers_lvl;
          3'h7: reset_lvl = ers_lvl;
          default: ;
        endcase
      end
      GRP_ONESHOT: begin
        edge_start = (sub != 3'h0);
        case (sub)
          3'h0: start_ev = 1'b1;
          3'h1: start_ev = rise;
          3'h2: start_ev = fall;
          3'h3: start_ev = rise || fall;
          3'h4: begin
            start_ev   = rise;
            reset_edge = rise;
          end
          3'h5: begin
            start_ev   = fall;
            reset_edge = fall;
          end
          3'h6: begin
            start_ev  = rise;
            reset_lvl = !debug_mode && !ers_lvl;
          end
          3'h7: begin
            start_ev  = fall;
            reset_lvl = ers_lvl;
          end
          default: ;
        endcase
      end
      GRP_MONO: begin
        edge_start = !reserved;
        case (sub)
          3'h1: start_ev = rise;
          3'h2: start_ev = fall;
          3'h3: start_ev = rise || fall;
          3'h6: begin
            edge_start = 1'b0;
            start_ev   = !debug_mode && ers_lvl;
            reset_lvl  = !debug_mode && !ers_lvl;
          end
          3'h7: begin
            edge_start = 1'b0;
            start_ev   = !debug_mode && !ers_lvl;
            reset_lvl  = ers_lvl;
          end
          default: ;
        endcase
      end
      default: ;
    endcase
    if (reserved) begin
      start_ev   = 1'b0;
      reset_edge = 1'b0;
      reset_lvl  = 1'b0;
    end
  end

  // run state, counter and enable bit
  always_comb begin
    next_ers_prev = ers_sync;
    next_enable   = enable;
    next_count    = count_value;
    next_state    = state;
    next_hold_cnt = hold_cnt;
    next_match    = 1'b0;
    at_match      = period_match;
    post_clear    = count_write || enable_set;
    if (enable_set) begin
      next_enable = 1'b1;
    end else if (enable_clear) begin
      next_enable = 1'b0;
    end
    if (count_write) begin
      next_count = count_write_data;
    end
    case (state)
      ST_IDLE: begin
        if (enable && !reserved) begin
          next_state = (edge_start || (grp == GRP_MONO && sub[2:1] == 2'h3)) ?
                       ST_ARM : ST_RUN;
        end
      end
      ST_ARM: begin
        if (!enable) begin
          next_state = ST_IDLE;
        end else if (start_ev) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable || reserved) begin
          next_state = ST_IDLE;
        end else if (at_match) begin
          next_count = COUNT_RST;
          // level-start modes 1011x are one-shots as well
          if (grp == GRP_ONESHOT || (grp == GRP_MONO && sub[2:1] == 2'h3)) begin
            next_enable = enable_set;
            next_state  = ST_IDLE;
          end else if (grp == GRP_MONO) begin
            next_state  = ST_ARM;
          end
        end else if (reset_edge) begin
          next_count    = COUNT_RST;
          next_hold_cnt = RESUME_DELAY;
          post_clear    = 1'b1;
        end else if (reset_lvl) begin
          next_count = COUNT_RST;
          post_clear = 1'b1;
        end else if (hold_cnt != 2'h0) begin
          next_hold_cnt = hold_cnt - 2'h1;
        end else if (gate_ok && !count_write) begin
          next_count = count_value + 8'h01;
          next_match = (next_count == period_value);
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (state != ST_RUN && !count_write && count_value == period_value) begin
      next_match = 1'b0;
    end
    if (srst) begin
      next_ers_prev = 1'b0;
      next_enable   = 1'b0;
      next_count    = COUNT_RST;
      next_state    = ST_IDLE;
      next_hold_cnt = 2'h0;
      next_match    = 1'b0;
    end
  end

  // register state
  always_ff @(posedge ref_clk) begin
    ers_prev     <= next_ers_prev;
    enable       <= next_enable;
    count_value  <= next_count;
    state        <= next_state;
    hold_cnt     <= next_hold_cnt;
    period_match <= next_match;
  end

  // postscaler on period matches
  postscaler u_post (
    .ref_clk          (ref_clk),
    .srst             (srst),
    .clear            (post_clear),
    .match            (at_match),
    .postscale_select (postscale_select),
    .postscaled_pulse (postscaled_pulse)
  );
endmodule // timer_hw_limit_mode_control

// ---- test/trig_source.sv ----
// far-side trigger source model
`timescale 1ns/1ps
module trig_source (
  // clock
  input  wire logic ref_clk,
  // requested level and line
  input  wire logic want,
  output logic      trig
);
  logic [3:0] gap;
  initial begin
    trig = 1'b0;
    gap  = 4'h0;
  end
  // follow request only seven clocks after the last edge
  always @(posedge ref_clk) begin
    if (want != trig && gap >= 4'h6) begin
      trig <= want;
      gap  <= 4'h0;
    end else if (gap != 4'hF) begin
      gap <= gap + 4'h1;
    end
  end
endmodule // trig_source

// ---- test/timer_hw_limit_mode_control_checker.sv ----
// port assertions for the mode control
`timescale 1ns/1ps
module timer_hw_limit_mode_control_checker
  import hlt_pkg::*;
(
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               srst,
  // control
  input wire logic               enable_set,
  input wire logic               enable_clear,
  input wire logic [MODE_W-1:0]  mode,
  input wire logic [COUNT_W-1:0] period_value,
  input wire logic               count_write,
  // status
  input wire logic               enable,
  input wire logic [COUNT_W-1:0] count_value,
  input wire logic               period_match
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // match and wrap steps
  sequence s_hit; period_match && !count_write; endsequence
  sequence s_wrap; count_value == 8'h00; endsequence
  match_value_a: assert property (period_match |-> count_value == period_value)
    else $error("match flag without equal count");
  match_wrap_a: assert property (s_hit |=> s_wrap)
    else $error("count not zero after match");
  oneshot_clear_a: assert property (s_hit ##0 ((mode[4:3] == 2'h1 ||
    (mode[4:3] == 2'h2 && mode[2:1] == 2'h3)) && !enable_set) |=> !enable)
    else $error("one-shot kept enable");
  mono_keep_a: assert property (s_hit ##0 (mode[4:3] == 2'h2 && mode[2:1] != 2'h3 &&
    !enable_clear) |=> enable)
    else $error("monostable dropped enable");
  reserved_hold_a: assert property ((mode[4:3] == 2'h3 && !count_write) [*3] |-> $stable(count_value))
    else $error("reserved mode moved count");
  en_set_a: assert property (enable_set |=> enable)
    else $error("enable not set");
  en_clear_a: assert property (enable_clear && !enable_set |=> !enable)
    else $error("enable not cleared");
  count_step_a: assert property ($changed(count_value) && !$past(count_write)
    |-> count_value == $past(count_value) + 8'h01 || count_value == 8'h00)
    else $error("count jumped");
endmodule // timer_hw_limit_mode_control_checker

// ---- test/test_timer_hw_limit_mode_control.sv ----
// self-checking bench for the mode control
`timescale 1ns/1ps
module test_timer_hw_limit_mode_control;
  import hlt_pkg::*;
  typedef struct {logic ce; logic en; int lo; int hi;} note_t;
  logic ref_clk = 1'h0, srst = 1'h1, enable_set = 1'h0, enable_clear = 1'h0;
  logic count_write = 1'h0, debug_mode = 1'h0, want = 1'h0;
  logic [4:0] mode = 5'h00;
  logic [7:0] period_value = 8'h10, count_write_data = 8'h00, count_value;
  logic [3:0] postscale_select = 4'h0;
  logic       trig, enable, period_match, postscaled_pulse;
  logic [4:0] rsv [4];
  int         err_count = 0, n_tests = 0;
  note_t      q[$];
  event       note_ev;
  int         n_pulse = 0;
  always #50 ref_clk = ~ref_clk;
  timer_hw_limit_mode_control u_timer_hw_limit_mode_control (.ref_clk(ref_clk), .srst(srst),
    .enable_set(enable_set), .enable_clear(enable_clear), .mode(mode),
    .period_value(period_value), .postscale_select(postscale_select),
    .count_write(count_write), .count_write_data(count_write_data), .debug_mode(debug_mode),
    .external_reset_trigger(trig), .enable(enable), .count_value(count_value),
    .period_match(period_match), .postscaled_pulse(postscaled_pulse));
  trig_source u_trig_source (.ref_clk(ref_clk), .want(want), .trig(trig));
  task automatic tick(int n); repeat (n) @(negedge ref_clk); endtask
  // note an expectation on the present outputs
  task automatic expect_now(logic ce, logic en, int lo, int hi);
    q.push_back('{ce, en, lo, hi});
    -> note_ev;
    tick(1);
  endtask
  task automatic check_pulse(int lo, int hi);
    n_tests++;
    if ((n_pulse >= lo && n_pulse <= hi) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t pulses %0d", $time, n_pulse);
    end
  endtask
  // count postscaled pulses where they are settled
  always @(negedge ref_clk) if (postscaled_pulse === 1'b1) n_pulse++;
  task automatic check_count(note_t n);
    n_tests++;
    if ((count_value >= n.lo && count_value <= n.hi) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t count %0d", $time, count_value);
    end
  endtask
  task automatic check_en(note_t n);
    n_tests++;
    if (enable !== n.en) begin
      err_count++;
      $display("[FAIL] %0t enable %b", $time, enable);
    end
  endtask
  // monitor takes the oldest note
  always @(note_ev) begin
    note_t n;
    n = q.pop_front();
    check_count(n);
    if (n.ce) check_en(n);
  end
  task automatic wait_match(int lim);
    int i;
    i = 0;
    while (period_match !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    if (i >= lim) begin
      err_count++;
      $display("[FAIL] %0t no match", $time);
    end
  endtask
  task automatic pulse_en(logic on);
    if (on) enable_set = 1'h1;
    else enable_clear = 1'h1;
    tick(1);
    enable_set = 1'h0;
    enable_clear = 1'h0;
  endtask
  task automatic start(logic [4:0] m, logic [7:0] p);
    pulse_en(1'h0);
    mode = m;
    period_value = p;
    count_write = 1'h1;
    tick(1);
    count_write = 1'h0;
    pulse_en(1'h1);
  endtask
  task automatic edge_to(logic v); want = v; tick(9); endtask
  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    int p;
    logic [4:0] em [3] = '{5'h03, 5'h04, 5'h05};
    logic       et [3] = '{1'h1, 1'h1, 1'h0};
    p = $urandom(32'h92f8189b);
    p = 3 + $urandom % 20;
    rsv = '{5'h10, 5'h14, 5'h15, 5'h18 | 5'($urandom % 8)};
    tick(4);
    srst = 1'h0;
    tick(1);
    start(5'h00, 8'(p)); wait_match(40); expect_now(0, 0, p, p);
    expect_now(1, 1, 0, 0);
    start(5'h08, 8'h05); wait_match(20); tick(1); expect_now(1, 0, 0, 0);
    tick(5); expect_now(1, 0, 0, 0);
    edge_to(0); start(5'h11, 8'h0C); tick(10); expect_now(1, 1, 0, 0);
    edge_to(1); wait_match(20); tick(1); expect_now(1, 1, 0, 0);
    edge_to(0); edge_to(1); wait_match(20);
    edge_to(0); start(5'h01, 8'h08); tick(10); expect_now(0, 0, 0, 0);
    edge_to(1); wait_match(20);
    foreach (em[i]) begin
      edge_to(!et[i]); start(em[i], 8'hC8); tick(30); expect_now(0, 0, 20, 31);
      edge_to(et[i]); expect_now(0, 0, 0, 8);
      debug_mode = 1'h1; edge_to(!et[i]); edge_to(et[i]);
      expect_now(0, 0, 20, 40); debug_mode = 1'h0;
    end
    for (int k = 0; k < 2; k++) begin
      edge_to(k[0]); start(5'h06 + k[4:0], 8'hC8); tick(12); expect_now(0, 0, 0, 0);
      edge_to(!k[0]); expect_now(0, 0, 2, 9);
    end
    edge_to(0); start(5'h09, 8'hC8); edge_to(1); tick(10);
    pulse_en(1'h0); pulse_en(1'h1); tick(15); expect_now(1, 1, 8, 20);
    edge_to(0); edge_to(1); expect_now(0, 0, 21, 45);
    edge_to(0); start(5'h0C, 8'hC8); edge_to(1); tick(10); expect_now(0, 0, 12, 18);
    edge_to(0); edge_to(1); expect_now(0, 0, 2, 8);
    edge_to(0); start(5'h16, 8'h06); tick(10); expect_now(1, 1, 0, 0);
    edge_to(1); wait_match(20); tick(1); expect_now(1, 0, 0, 0);
    postscale_select = 4'h1; start(5'h00, 8'h04); n_pulse = 0; tick(80);
    check_pulse(7, 9);
    postscale_select = 4'h0;
    foreach (rsv[i]) begin
      start(rsv[i], 8'h04); edge_to(!want); edge_to(!want); expect_now(0, 0, 0, 0);
    end
    report_and_stop();
  end
  // watchdog
  initial begin
    #3000000;
    err_count++;
    report_and_stop();
  end
endmodule // test_timer_hw_limit_mode_control
bind timer_hw_limit_mode_control timer_hw_limit_mode_control_checker u_chk (
  .ref_clk(ref_clk), .srst(srst), .enable_set(enable_set), .enable_clear(enable_clear),
  .mode(mode), .period_value(period_value), .count_write(count_write), .enable(enable),
  .count_value(count_value), .period_match(period_match));
